/* File: pkg/sfhp_pkg.sv */
// Shared constants and types of the speech frame host port
package sfhp_pkg;

   // Command byte fields
   localparam int unsigned CMD_STOP_BIT     = 4;
   localparam int unsigned CMD_LOOP_EN_BIT  = 3;
   localparam int unsigned CMD_LOOP_VAL_BIT = 2;
   localparam int unsigned CMD_GATE_EN_BIT  = 1;
   localparam int unsigned CMD_GATE_VAL_BIT = 0;
   localparam logic [7:0]  CMD_RESET        = 8'h1A;

   // Status byte: request flag position
   localparam int unsigned STATUS_REQ_BIT = 7;

   // Parameter group: four bytes, first byte sent sits in [31:24]
   localparam int unsigned GROUP_BYTES = 4;
   localparam int unsigned F1_SPAN_LSB = 30;
   localparam int unsigned F2_SPAN_LSB = 28;
   localparam int unsigned F3_SPAN_LSB = 26;
   localparam int unsigned F4_SPAN_LSB = 24;
   localparam int unsigned F3_FREQ_LSB = 21;
   localparam int unsigned F2_FREQ_LSB = 16;
   localparam int unsigned F1_FREQ_LSB = 11;
   localparam int unsigned LOUD_LSB    = 7;
   localparam int unsigned LEN_LSB     = 5;
   localparam int unsigned SLOPE_LSB   = 0;

   // Timing at a 40 ns clock
   localparam int unsigned CLK_NS         = 40;
   localparam int unsigned FRAME_MIN_NS   = 8000000;
   localparam int unsigned FRAME_MIN_CYC  = FRAME_MIN_NS / CLK_NS;
   localparam int unsigned REQ_NEXT_NS    = 3000;
   localparam int unsigned REQ_NEXT_CYC   = REQ_NEXT_NS / CLK_NS;
   localparam int unsigned OUT_SAMPLE_NS  = 15625;
   localparam int unsigned OUT_SAMPLE_CYC = OUT_SAMPLE_NS / CLK_NS;
   localparam int unsigned INTERP_STEPS   = 8;
   localparam int unsigned DECAY_SAMPLES  = 4;

   // Host plain port register map
   localparam logic [1:0] HOST_ADDR_PITCH  = 2'h0;
   localparam logic [1:0] HOST_ADDR_GROUP  = 2'h1;
   localparam logic [1:0] HOST_ADDR_CMD    = 2'h2;
   localparam logic [1:0] HOST_ADDR_STATUS = 2'h3;

   // Device mode states
   typedef enum logic [3:0] {
      SFHP_STOP   = 4'h1,
      SFHP_ACTIVE = 4'h2,
      SFHP_REPEAT = 4'h4,
      SFHP_DECAY  = 4'h8
   } sfhp_mode_type;

   // Host pin sequencer states
   typedef enum logic [3:0] {
      SFHP_H_IDLE = 4'h1,
      SFHP_H_RDW  = 4'h2,
      SFHP_H_RDS  = 4'h4,
      SFHP_H_WR   = 4'h8
   } sfhp_host_state_type;

endpackage

/* File: pkg/sfhp_if.sv */
// Parallel pins between the host controller and the synthesizer
`timescale 1ns/1ps
interface sfhp_if;
   logic       chip_sel_n;
   logic       store_strobe_n;
   logic       direction_n;
   logic       port_select;
   logic [7:0] host_data;
   logic       host_data_oe;
   logic [7:0] dev_data;
   logic       dev_data_oe;
   logic       req_pin_oe;
   logic [7:0] data_bus;
   logic       req_n;

   // Resolved bus level, pulled high when nobody drives
   assign data_bus = host_data_oe ? host_data :
                     (dev_data_oe ? dev_data : 8'hFF);
   // Open-drain request, pulled high
   assign req_n = req_pin_oe ? 1'b0 : 1'b1;

   modport host (
      output chip_sel_n, store_strobe_n, direction_n, port_select,
      output host_data, host_data_oe,
      input  data_bus, req_n
   );
   modport dev (
      input  chip_sel_n, store_strobe_n, direction_n, port_select,
      input  data_bus,
      output dev_data, dev_data_oe, req_pin_oe
   );
endinterface

/* File: rtl/sfhp_dev.sv */
// Synthesizer end: mode control, byte pacing and sample output
//
// Summary of operation
// R1: Four bytes form one frame parameter group.
// R2: Length code selects 8/16/32/64 ms frame.
// R3: Output samples at 64 kHz, linearly interpolated.
// R4: Stop mode: silence, request flag held high.
// R5: Late data, no loop: decaying replay, stop.
// R6: Late data, loop: repeat frame until released.
// R7: Data write decode from four control pins.
// R8: Data writes ignored while request flag low.
// R9: After stop, first byte is pitch.
// R10: Fixed field widths inside a parameter group.
// R11: Accepted write clears flag; quick reassert.
// R12: Next group request right after frame start.
// R13: Sound starts after pitch plus group.
// R14: Status read shows flag on bit 7.
// R15: Command write decode from four pins.
// R16: Stop bit forces stop mode immediately.
// R17: Loop setting changes only when enabled.
// R18: Pin gate setting changes only when enabled.
// R19: Low gate input suppresses request pin.
// R20: Reset equals command 1A.
// R21: Inter-byte request within 3 us.
// R22: Data bus released unless status read.
// R23: Group bytes unpacked in fixed order.
`timescale 1ns/1ps
module sfhp_dev #(
   parameter int unsigned FRAME_MIN_CYC = sfhp_pkg::FRAME_MIN_CYC
) (
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        reset,
   // Pins from the host
   sfhp_if.dev              bus,
   // Request gate pin
   input  wire logic        gate_pin_input,
   // Frame parameters for the filter
   output logic [31:0]      frame_params,
   output logic             frame_start,
   // Audio samples
   output logic [7:0]       audio_sample,
   output logic             sample_strobe
);
   import sfhp_pkg::*;

   typedef struct packed {
      sfhp_mode_type mode;
      logic          need_byte;
      logic          pitch_wanted;
      logic [1:0]    byte_idx;
      logic [31:0]   group;
      logic          pend_full;
      logic [31:0]   cur;
      logic [7:0]    pitch;
      logic          loop_on_late;
      logic          pin_flag_gate;
      logic [6:0]    req_wait;
      logic [23:0]   frame_cnt;
      logic [8:0]    tick_cnt;
      logic [2:0]    step;
      logic [7:0]    phase;
      logic [3:0]    level;
      logic [1:0]    decay_cnt;
      logic [7:0]    prev;
      logic [7:0]    now;
      logic [7:0]    out;
      logic          strobe;
      logic          fstart;
      logic          data_oe;
      logic [7:0]    data_out;
      logic          req_oe;
   } sfhp_dev_state_type;

   sfhp_dev_state_type r;
   sfhp_dev_state_type next_r;

   logic              wr_data;
   logic              wr_cmd;
   logic [7:0]        din;
   logic              start_new;
   logic [1:0]        len_code;
   logic signed [9:0] diff;
   logic signed [13:0] prod;
   logic signed [9:0] sum;

   // Pin decode of the two write kinds
   assign din     = bus.data_bus;
   assign wr_data = !bus.chip_sel_n && !bus.store_strobe_n
                    && bus.direction_n && !bus.port_select;     // R7
   assign wr_cmd  = !bus.chip_sel_n && !bus.store_strobe_n
                    && bus.direction_n && bus.port_select;      // R15
   assign len_code = r.group[LEN_LSB +: 2];

   // Next state of the whole synthesizer end
   always_comb begin
      next_r = r;
      start_new = 1'b0;
      diff = '0;
      prod = '0;
      sum = '0;
      next_r.fstart = 1'b0;
      next_r.strobe = 1'b0;
      // Status read drives the flag, bus released otherwise
      next_r.data_oe = !bus.chip_sel_n && !bus.direction_n;  // R14 R22
      next_r.data_out = 8'h00;
      next_r.data_out[STATUS_REQ_BIT] = r.need_byte;         // R14
      next_r.req_oe = r.need_byte && r.pin_flag_gate
                      && gate_pin_input;                     // R18 R19

      // Delayed reassert of the byte request
      if (r.req_wait != 7'h00) begin
         next_r.req_wait = r.req_wait - 7'h01;
         if (r.req_wait == 7'h01) begin
            next_r.need_byte = 1'b1;                         // R11 R21
         end
      end

      // Accepted data byte
      if (wr_data && r.need_byte) begin                      // R8
         next_r.need_byte = 1'b0;                            // R11
         next_r.req_wait = 7'(REQ_NEXT_CYC);                 // R21
         if (r.pitch_wanted) begin
            next_r.pitch = din;                              // R9
            next_r.pitch_wanted = 1'b0;
         end else begin
            next_r.group = {r.group[23:0], din};             // R23 R10
            next_r.byte_idx = r.byte_idx + 2'h1;
            if (r.byte_idx == 2'(GROUP_BYTES - 1)) begin
               next_r.pend_full = 1'b1;                      // R1
               next_r.req_wait = 7'h00;
            end
         end
      end

      // Frame sequencing
      case (r.mode)
         SFHP_STOP: begin
            if (r.pend_full) begin
               start_new = 1'b1;                             // R13
            end
         end
         SFHP_ACTIVE, SFHP_REPEAT: begin
            if (r.frame_cnt == 24'h000000) begin
               if (r.pend_full) begin
                  start_new = 1'b1;
               end else if (r.loop_on_late) begin
                  next_r.mode = SFHP_REPEAT;                 // R6
                  next_r.frame_cnt = 24'((FRAME_MIN_CYC
                     << r.cur[LEN_LSB +: 2]) - 1);
                  next_r.fstart = 1'b1;
               end else begin
                  next_r.mode = SFHP_DECAY;                  // R5
                  next_r.frame_cnt = 24'((FRAME_MIN_CYC
                     << r.cur[LEN_LSB +: 2]) - 1);
                  next_r.fstart = 1'b1;
               end
            end else begin
               next_r.frame_cnt = r.frame_cnt - 24'h000001;
            end
         end
         SFHP_DECAY: begin
            if (r.frame_cnt != 24'h000000) begin
               next_r.frame_cnt = r.frame_cnt - 24'h000001;
            end else if (r.pend_full) begin
               start_new = 1'b1;
            end else begin
               next_r.mode = SFHP_STOP;                      // R5 R4
               next_r.need_byte = 1'b1;
               next_r.pitch_wanted = 1'b1;
               next_r.byte_idx = 2'h0;
               next_r.req_wait = 7'h00;
            end
         end
         default: begin
            next_r.mode = SFHP_STOP;
         end
      endcase

      // Apply a complete group to a fresh frame
      if (start_new) begin
         next_r.cur = r.group;                               // R1
         next_r.pend_full = 1'b0;
         next_r.byte_idx = 2'h0;
         next_r.mode = SFHP_ACTIVE;
         next_r.frame_cnt = 24'((FRAME_MIN_CYC << len_code) - 1); // R2
         next_r.level = r.group[LOUD_LSB +: 4];
         next_r.req_wait = 7'(REQ_NEXT_CYC);                 // R12
         next_r.fstart = 1'b1;
         if (r.mode != SFHP_STOP) begin
            next_r.pitch = r.pitch + {{3{r.group[SLOPE_LSB + 4]}},
                                      r.group[SLOPE_LSB +: 5]};
         end
      end

      // Sample generator with 8-step linear interpolation
      if (r.mode == SFHP_STOP) begin
         next_r.tick_cnt = 9'h000;
         next_r.step = 3'h0;
         next_r.prev = 8'h00;
         next_r.now = 8'h00;
         next_r.out = 8'h00;                                 // R4
      end else if (r.tick_cnt == 9'(OUT_SAMPLE_CYC - 1)) begin
         next_r.tick_cnt = 9'h000;
         next_r.strobe = 1'b1;                               // R3
         next_r.step = r.step + 3'h1;
         diff = $signed({2'b00, r.now}) - $signed({2'b00, r.prev});
         prod = diff * $signed({1'b0, r.step});
         sum = $signed({2'b00, r.prev}) + prod[12:3];        // R3
         next_r.out = sum[7:0];
         if (r.step == 3'(INTERP_STEPS - 1)) begin
            next_r.prev = r.now;
            next_r.now = r.phase[7] ? {r.level, 4'h0} : 8'h00;
            next_r.phase = r.phase + r.pitch;
            if (r.mode == SFHP_DECAY) begin
               next_r.decay_cnt = r.decay_cnt + 2'h1;
               if (r.decay_cnt == 2'(DECAY_SAMPLES - 1)
                   && r.level != 4'h0) begin
                  next_r.level = r.level - 4'h1;             // R5
               end
            end
         end
      end else begin
         next_r.tick_cnt = r.tick_cnt + 9'h001;
      end

      // Command write, stop has final say
      if (wr_cmd) begin
         if (din[CMD_LOOP_EN_BIT]) begin
            next_r.loop_on_late = din[CMD_LOOP_VAL_BIT];     // R17
         end
         if (din[CMD_GATE_EN_BIT]) begin
            next_r.pin_flag_gate = din[CMD_GATE_VAL_BIT];    // R18
         end
         if (din[CMD_STOP_BIT]) begin
            next_r.mode = SFHP_STOP;                         // R16
            next_r.need_byte = 1'b1;
            next_r.pitch_wanted = 1'b1;
            next_r.byte_idx = 2'h0;
            next_r.pend_full = 1'b0;
            next_r.req_wait = 7'h00;
            next_r.fstart = 1'b0;
         end
      end
   end

   // State register, reset equals the power-on command
   always_ff @(posedge clk) begin
      if (reset) begin
         next_r_reset: begin
            r <= '0;
            r.mode <= SFHP_STOP;                             // R20 R4
            r.need_byte <= 1'b1;
            r.pitch_wanted <= 1'b1;
            r.loop_on_late <= CMD_RESET[CMD_LOOP_VAL_BIT];   // R20
            r.pin_flag_gate <= CMD_RESET[CMD_GATE_VAL_BIT];  // R20
         end
      end else begin
         r <= next_r;
      end
   end

   // Outputs straight from the state register
   assign bus.dev_data    = r.data_out;
   assign bus.dev_data_oe = r.data_oe;
   assign bus.req_pin_oe  = r.req_oe;
   assign frame_params    = r.cur;
   assign frame_start     = r.fstart;
   assign audio_sample    = r.out;
   assign sample_strobe   = r.strobe;
endmodule // sfhp_dev

/* File: rtl/sfhp_host.sv */
// Host end: drives the parallel pins from a plain register port
`timescale 1ns/1ps
module sfhp_host (
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        reset,
   // Plain register port
   input  wire logic [1:0]  addr,
   input  wire logic [31:0] wdata,
   input  wire logic        wr,
   input  wire logic        rd,
   output logic [31:0]      rdata,
   // Pins to the synthesizer
   sfhp_if.host             bus
);
   import sfhp_pkg::*;

   typedef struct packed {
      sfhp_host_state_type st;
      logic [31:0]         queue;
      logic [2:0]          qcnt;
      logic                cmd_pend;
      logic [7:0]          cmd;
      logic                need_seen;
      logic                cs_n;
      logic                strobe_n;
      logic                dir_n;
      logic                psel;
      logic [7:0]          dout;
      logic                doe;
      logic [31:0]         rdata;
   } sfhp_host_reg_type;

   sfhp_host_reg_type r;
   sfhp_host_reg_type next_r;

   // Next state of the pin sequencer and register port
   always_comb begin
      next_r = r;
      next_r.rdata = 32'h00000000;
      if (rd && addr == HOST_ADDR_STATUS) begin
         next_r.rdata = {24'h000000, r.need_seen, 5'h00,
                         r.cmd_pend, (r.qcnt != 3'h0)};
      end
      if (wr) begin
         if (addr == HOST_ADDR_PITCH && r.qcnt == 3'h0) begin
            next_r.queue = {wdata[7:0], 24'h000000};
            next_r.qcnt = 3'h1;
         end else if (addr == HOST_ADDR_GROUP && r.qcnt == 3'h0) begin
            next_r.queue = wdata;                            // R23
            next_r.qcnt = 3'(GROUP_BYTES);                   // R1
         end else if (addr == HOST_ADDR_CMD) begin
            next_r.cmd = wdata[7:0];
            next_r.cmd_pend = 1'b1;
         end
      end
      case (r.st)
         SFHP_H_IDLE: begin
            if (r.cmd_pend) begin
               next_r.st = SFHP_H_WR;
               next_r.cs_n = 1'b0;                           // R15
               next_r.strobe_n = 1'b0;
               next_r.dir_n = 1'b1;
               next_r.psel = 1'b1;
               next_r.dout = r.cmd;
               next_r.doe = 1'b1;
               next_r.cmd_pend = wr && addr == HOST_ADDR_CMD;
            end else if (r.qcnt != 3'h0 && r.need_seen) begin // R8
               next_r.st = SFHP_H_WR;
               next_r.cs_n = 1'b0;                           // R7
               next_r.strobe_n = 1'b0;
               next_r.dir_n = 1'b1;
               next_r.psel = 1'b0;
               next_r.dout = r.queue[31:24];                 // R23
               next_r.doe = 1'b1;
               next_r.queue = {r.queue[23:0], 8'h00};
               next_r.qcnt = r.qcnt - 3'h1;
               next_r.need_seen = 1'b0;
            end else begin
               next_r.st = SFHP_H_RDW;
               next_r.cs_n = 1'b0;
               next_r.dir_n = 1'b0;
            end
         end
         SFHP_H_RDW: begin
            next_r.st = SFHP_H_RDS;
         end
         SFHP_H_RDS: begin
            next_r.need_seen = bus.data_bus[STATUS_REQ_BIT]; // R8
            next_r.st = SFHP_H_IDLE;
            next_r.cs_n = 1'b1;
            next_r.dir_n = 1'b1;
         end
         SFHP_H_WR: begin
            next_r.st = SFHP_H_IDLE;
            next_r.cs_n = 1'b1;
            next_r.strobe_n = 1'b1;
            next_r.doe = 1'b0;
         end
         default: begin
            next_r.st = SFHP_H_IDLE;
         end
      endcase
   end

   // State register
   always_ff @(posedge clk) begin
      if (reset) begin
         r <= '0;
         r.st <= SFHP_H_IDLE;
         r.cs_n <= 1'b1;
         r.strobe_n <= 1'b1;
         r.dir_n <= 1'b1;
      end else begin
         r <= next_r;
      end
   end

   // Outputs straight from the state register
   assign rdata              = r.rdata;
   assign bus.chip_sel_n     = r.cs_n;
   assign bus.store_strobe_n = r.strobe_n;
   assign bus.direction_n    = r.dir_n;
   assign bus.port_select    = r.psel;
   assign bus.host_data      = r.dout;
   assign bus.host_data_oe   = r.doe;
endmodule // sfhp_host

/* File: test/sfhp_checker.sv */
// Pin-level checks on the link between the host end and the synthesizer
`timescale 1ns/1ps
module sfhp_checker (
   // Clock and reset
   input wire logic clk,
   input wire logic reset,
   // Link pins
   input wire logic chip_sel_n,
   input wire logic store_strobe_n,
   input wire logic direction_n,
   input wire logic port_select,
   input wire logic host_data_oe,
   input wire logic dev_data_oe,
   input wire logic req_pin_oe
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);

   // Data byte offered while the request pin showed a pending request
   sequence data_write_s;
      !chip_sel_n && !store_strobe_n && direction_n && !port_select
         && req_pin_oe;
   endsequence
   // Status read: select and read direction both low
   sequence status_read_s;
      !chip_sel_n && !direction_n;
   endsequence

   // Link pins quiet in the first cycle after reset
   chk_reset_quiet: assert property (
      $fell(reset) |-> !req_pin_oe && !dev_data_oe && chip_sel_n)
      else $error("link not quiet after reset");
   // Status read drives the bus one edge later
   chk_status_drive: assert property (
      status_read_s |=> dev_data_oe)
      else $error("status not driven on read");
   // Bus released once select or read direction goes away
   chk_bus_release: assert property (
      (chip_sel_n || direction_n) |=> !dev_data_oe)
      else $error("data bus not released");
   // Device drives only after a read cycle
   chk_bus_cause: assert property (
      dev_data_oe |-> $past(chip_sel_n) == 1'b0
         && $past(direction_n) == 1'b0)
      else $error("device drove bus without read");
   // Never both ends on the bus
   chk_no_contention: assert property (
      !(host_data_oe && dev_data_oe))
      else $error("bus contention");
   // Write strobe is a single cycle low
   chk_strobe_pulse: assert property (
      $fell(store_strobe_n) |=> store_strobe_n)
      else $error("write strobe too long");
   // Host drives data with write direction during a write
   chk_write_drive: assert property (
      (!store_strobe_n && !chip_sel_n) |-> host_data_oe && direction_n)
      else $error("write without data drive");
   // Accepted byte drops the request for a while
   chk_write_drops_req: assert property (
      data_write_s |-> ##2 (!req_pin_oe) [*8])
      else $error("request not cleared by write");
endmodule // sfhp_checker

/* File: test/tb_speech_frame_host_port.sv */
// Testbench of host end and synthesizer joined over the parallel link
`timescale 1ns/1ps
module tb_speech_frame_host_port;
   import sfhp_pkg::*;
   localparam int unsigned FRAME = 1000;
   logic        clk, reset, gate_pin_input, wr, rd;
   logic [1:0]  addr;
   logic [31:0] wdata, rdata, frame_params, st;
   logic        frame_start, sample_strobe;
   logic [7:0]  audio_sample;
   int          fails, samples_checked, cyc, last_start, period, frames;
   int          last_s, spacing, n, heard;

   sfhp_if link ();
   sfhp_host i_sfhp_host (.clk(clk), .reset(reset), .addr(addr),
      .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .bus(link));
   sfhp_dev #(.FRAME_MIN_CYC(FRAME)) i_sfhp_dev (.clk(clk), .reset(reset),
      .bus(link), .gate_pin_input(gate_pin_input),
      .frame_params(frame_params), .frame_start(frame_start),
      .audio_sample(audio_sample), .sample_strobe(sample_strobe));
   sfhp_checker i_sfhp_checker (.clk(clk), .reset(reset),
      .chip_sel_n(link.chip_sel_n), .store_strobe_n(link.store_strobe_n),
      .direction_n(link.direction_n), .port_select(link.port_select),
      .host_data_oe(link.host_data_oe), .dev_data_oe(link.dev_data_oe),
      .req_pin_oe(link.req_pin_oe));

   // Clock of 40 ns
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   // Frame start times and sample spacing
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (frame_start === 1'b1) begin
         frames     <= frames + 1;
         period     <= cyc - last_start;
         last_start <= cyc;
      end
      if (sample_strobe === 1'b1) begin
         spacing <= cyc - last_s;
         last_s  <= cyc;
      end
      // Any non-silent sample seen so far
      if (audio_sample != 8'h00) begin
         heard <= heard + 1;
      end
   end

   // Parameter group word with a chosen length code
   function automatic logic [31:0] grp(input logic [1:0] len);
      return {8'hA5, 3'h5, 5'h11, 5'h0B, 4'hC, len, 5'h00};
   endfunction

   task automatic cmp(input string what, input logic [31:0] exp,
                      input logic [31:0] got);
      samples_checked++;
      if (got !== exp) begin
         fails++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic wr_reg(input logic [1:0] a, input logic [31:0] d);
      @(posedge clk);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge clk);
      wr    <= 1'b0;
   endtask

   task automatic rd_reg(input logic [1:0] a, output logic [31:0] d);
      @(posedge clk);
      addr <= a;
      rd   <= 1'b1;
      @(posedge clk);
      rd   <= 1'b0;
      #1 d = rdata;
   endtask

   // Poll until the host has nothing pending
   task automatic wait_idle();
      int k;
      k = 0;
      do begin
         rd_reg(HOST_ADDR_STATUS, st);
         k++;
      end while (st[1:0] !== 2'b00 && k < 5000);
      cmp("host idle", 32'h0, 32'(st[1:0]));
   endtask

   task automatic wait_frames(input int cnt);
      int k;
      k = 0;
      while (frames < cnt && k < 20000) begin
         @(posedge clk);
         k++;
      end
      #1 cmp("frame count", 32'(cnt), 32'(frames));
   endtask

   task automatic pin_is(input logic e);
      repeat (20) @(posedge clk);
      #1 cmp("request pin", 32'(e), 32'(link.req_n));
   endtask

   task automatic conclude();
      $display("checks %0d mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   // Watchdog against a hang
   initial begin
      repeat (90000) @(posedge clk);
      fails++;
      conclude();
   end

   // Main sequence
   initial begin
      reset = 1'b1;
      gate_pin_input = 1'b1;
      wr = 1'b0;
      rd = 1'b0;
      addr = 2'h0;
      wdata = 32'h0;
      {cyc, frames, last_start, period, fails, samples_checked} = '0;
      {last_s, spacing, heard} = '0;
      repeat (2) @(posedge clk);
      reset <= 1'b0;
      repeat (100) @(posedge clk);
      rd_reg(HOST_ADDR_STATUS, st);
      cmp("status flag", 32'h1, 32'(st[STATUS_REQ_BIT]));
      cmp("request pin", 32'h1, 32'(link.req_n));
      cmp("audio", 32'h0, 32'(audio_sample));
      $display("test reset state done");

      // Request pin gating by command and by pin
      wr_reg(HOST_ADDR_CMD, 32'h03);
      pin_is(1'b0);
      @(posedge clk) gate_pin_input <= 1'b0;
      pin_is(1'b1);
      @(posedge clk) gate_pin_input <= 1'b1;
      pin_is(1'b0);
      wr_reg(HOST_ADDR_CMD, 32'h01);
      pin_is(1'b0);
      wr_reg(HOST_ADDR_CMD, 32'h02);
      pin_is(1'b1);
      wr_reg(HOST_ADDR_CMD, 32'h07);
      pin_is(1'b0);
      $display("test request gating done");

      // Pitch byte, then request back in time
      wr_reg(HOST_ADDR_PITCH, 32'h40);
      // Pins are looked at 1 ns after each edge, once settled
      n = 0;
      while (link.store_strobe_n !== 1'b0 && n < 500) begin
         @(posedge clk);
         #1 n++;
      end
      while (link.req_n !== 1'b1 && n < 500) begin
         @(posedge clk);
         #1 n++;
      end
      n = 0;
      while (link.req_n !== 1'b0 && n < 500) begin
         @(posedge clk);
         #1 n++;
      end
      cmp("request gap", 32'h1, 32'(n <= REQ_NEXT_CYC + 3));
      cmp("frames before group", 32'h0, 32'(frames));
      cmp("sound before group", 32'h0, 32'(heard));

      // One frame of every length, then a decaying replay and stop
      for (int i = 0; i < 4; i++) begin
         wait_idle();
         wr_reg(HOST_ADDR_GROUP, grp(2'(3 - i)));
         wait_frames(i + 1);
         cmp("frame word", grp(2'(3 - i)), frame_params);
         if (i > 0)
            cmp("frame length", 32'(FRAME << (4 - i)), 32'(period));
      end
      repeat (FRAME / 2) @(posedge clk);
      cmp("sample spacing", 32'(OUT_SAMPLE_CYC), 32'(spacing));
      cmp("sound heard", 32'h1, 32'(heard > 0));
      wait_frames(5);
      cmp("decay start", 32'(FRAME), 32'(period));
      repeat (FRAME * 2) @(posedge clk);
      #1 cmp("frames after decay", 32'h5, 32'(frames));
      cmp("audio in stop", 32'h0, 32'(audio_sample));
      rd_reg(HOST_ADDR_STATUS, st);
      cmp("status flag", 32'h1, 32'(st[STATUS_REQ_BIT]));
      $display("test frame sequence done");

      // Endless repeat, broken by a stop command
      wr_reg(HOST_ADDR_CMD, 32'h0F);
      wr_reg(HOST_ADDR_PITCH, 32'h40);
      wait_idle();
      wr_reg(HOST_ADDR_GROUP, grp(2'h0));
      wait_frames(8);
      cmp("repeat length", 32'(FRAME), 32'(period));
      wr_reg(HOST_ADDR_CMD, 32'h10);
      repeat (FRAME * 2) @(posedge clk);
      #1 cmp("frames after stop", 32'h8, 32'(frames));
      cmp("audio in stop", 32'h0, 32'(audio_sample));
      pin_is(1'b0);
      $display("test repeat and stop done");

      // Loop setting kept by stop, then slow stop
      wr_reg(HOST_ADDR_PITCH, 32'h40);
      wait_idle();
      wr_reg(HOST_ADDR_GROUP, grp(2'h0));
      wait_frames(11);
      wr_reg(HOST_ADDR_CMD, 32'h08);
      repeat (FRAME * 4) @(posedge clk);
      #1 cmp("frames after slow stop", 32'd12, 32'(frames));
      $display("test slow stop done");
      conclude();
   end
endmodule // tb_speech_frame_host_port
